/* design/pcm_port_mux.sv */
// port c7, port d and port e alternate-function mux with apb register access
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

// How it works
// - pc_cfg bit 7 picks port bit or waveform address bit 7 on pin c7.
// - port d carries upper bus byte only with bus mode and word-wide set.
// - pe_cfg bit n picks port or alternate function for port e pin n.
// - timer 0 overflow gives one high core-clock-output cycle, active high.
// - in split mode timer 0 output pulses on low-byte overflow.
// - timer 1 output likewise, low-byte overflow in split mode.
// - timer 2 output high one clock per overflow, low otherwise.
// - serial 0 echo shows data only in mode 0, else held at one.
// - serial 1 echo shows data in mode 0, high in modes 1 to 3.
// - interrupt 6 input is rising-edge detected; board drives low-to-high.
// - falling edge on timer 2 reload input reloads timer 2.
// - reload input ignored unless timer 2 external-enable bit set.
// - pin e7 alternate outputs waveform address bit 8.
module pcm_port_mux #(
  parameter logic [7:0] CORE_CLOCK_OUTPUT_CYCLES = pcm_pkg::CORE_CLOCK_OUTPUT_CYCLES_DEF
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire pcm_pkg::pcm_timer_ev_t timer_ev,
  input  wire pcm_pkg::pcm_serial_t  serial_port0,
  input  wire pcm_pkg::pcm_serial_t  serial_port1,
  input  wire logic                  wave_addr_bit7,
  input  wire logic                  wave_addr_bit8,
  input  wire logic [7:0]            bus_data_hi_out,
  input  wire logic                  bus_data_hi_oe,
  output logic      [7:0]            bus_data_hi_in,
  output logic                       ext_irq6_pulse,
  output logic                       timer2_reload_pulse,
  input  wire logic                  pc7_in,
  output logic                       pc7_out,
  output logic                       pc7_oe_n,
  input  wire logic [7:0]            pd_in,
  output logic      [7:0]            pd_out,
  output logic      [7:0]            pd_oe_n,
  input  wire logic [7:0]            pe_in,
  output logic      [7:0]            pe_out,
  output logic      [7:0]            pe_oe_n
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pcm_pkg::pcm_cfg_t  cfg;
    logic               pc7_out;
    logic               pc7_oe_n;
    pcm_pkg::pcm_pin8_t pd;
    pcm_pkg::pcm_pin8_t pe;
    logic [7:0]         t0_cnt;
    logic [7:0]         t1_cnt;
    logic               t2_out;
    logic               rx0_out;
    logic               rx1_out;
    logic [31:0]        rdata;
  } pcm_state_t;

  pcm_state_t st_ff;
  pcm_state_t nxt_st;

  // returns {out, oe_n}; oe_n low while the pin is driven
  function automatic logic [1:0] pcm_pin_sel(
    input logic sel,
    input logic alt_val,
    input logic alt_drive,
    input logic dat,
    input logic dir
  );
    if (sel) begin
      pcm_pin_sel = {alt_val & alt_drive, ~alt_drive};
    end else begin
      pcm_pin_sel = {dat, ~dir};
    end
  endfunction : pcm_pin_sel

  // stretches an overflow strobe to one core-clock-output cycle
  function automatic logic [7:0] pcm_stretch(
    input logic       ev,
    input logic [7:0] cnt
  );
    if (ev) begin
      pcm_stretch = CORE_CLOCK_OUTPUT_CYCLES;
    end else if (cnt != 8'h00) begin
      pcm_stretch = cnt - 8'h01;
    end else begin
      pcm_stretch = 8'h00;
    end
  endfunction : pcm_stretch

  logic       acc_wr;
  logic       setup_rd;
  logic       mapped;
  logic       bus_hi_sel;
  logic       t0_ev;
  logic       t1_ev;
  logic [7:0] alt_val;
  logic [7:0] alt_drive;
  logic [1:0] pin_bits;
  logic [7:0] wd;

  assign wd       = pwdata[7:0];
  assign acc_wr   = psel && penable && pwrite && mapped;
  assign setup_rd = psel && !penable && !pwrite;

  // ****************************************
  // address decode
  // ****************************************
  always_comb begin
    if (paddr == pcm_pkg::ADDR_PORT_C_CONFIG) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_PORT_E_CONFIG) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_INTERFACE_CFG) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_ENDPOINT_FIFO) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_PORT_C_DATA) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_PORT_C_DIR) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_PORT_D_DATA) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_PORT_D_DIR) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_PORT_E_DATA) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_PORT_E_DIR) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_PIN_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == pcm_pkg::ADDR_TIMER2_CONTROL) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;

    // register writes take effect at the access edge only
    if (acc_wr) begin
      if (paddr == pcm_pkg::ADDR_PORT_C_CONFIG) begin
        nxt_st.cfg.pc_cfg = wd;
      end else if (paddr == pcm_pkg::ADDR_PORT_E_CONFIG) begin
        nxt_st.cfg.pe_cfg = wd;
      end else if (paddr == pcm_pkg::ADDR_INTERFACE_CFG) begin
        nxt_st.cfg.if_mode = wd[1:0];
      end else if (paddr == pcm_pkg::ADDR_ENDPOINT_FIFO) begin
        nxt_st.cfg.ep_wide = wd[pcm_pkg::WORDWIDE_BIT];
      end else if (paddr == pcm_pkg::ADDR_PORT_C_DATA) begin
        nxt_st.cfg.pc_dat = wd[pcm_pkg::PC_ALT_BIT];
      end else if (paddr == pcm_pkg::ADDR_PORT_C_DIR) begin
        nxt_st.cfg.pc_dir = wd[pcm_pkg::PC_ALT_BIT];
      end else if (paddr == pcm_pkg::ADDR_PORT_D_DATA) begin
        nxt_st.cfg.pd_dat = wd;
      end else if (paddr == pcm_pkg::ADDR_PORT_D_DIR) begin
        nxt_st.cfg.pd_dir = wd;
      end else if (paddr == pcm_pkg::ADDR_PORT_E_DATA) begin
        nxt_st.cfg.pe_dat = wd;
      end else if (paddr == pcm_pkg::ADDR_PORT_E_DIR) begin
        nxt_st.cfg.pe_dir = wd;
      end else if (paddr == pcm_pkg::ADDR_TIMER2_CONTROL) begin
        nxt_st.cfg.timer2_control = wd;
      end
    end

    // read data is captured in the setup cycle so it leaves a flop
    if (setup_rd) begin
      if (paddr == pcm_pkg::ADDR_PORT_C_CONFIG) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.pc_cfg};
      end else if (paddr == pcm_pkg::ADDR_PORT_E_CONFIG) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.pe_cfg};
      end else if (paddr == pcm_pkg::ADDR_INTERFACE_CFG) begin
        nxt_st.rdata = {30'h0000_0000, st_ff.cfg.if_mode};
      end else if (paddr == pcm_pkg::ADDR_ENDPOINT_FIFO) begin
        nxt_st.rdata = {31'h0000_0000, st_ff.cfg.ep_wide};
      end else if (paddr == pcm_pkg::ADDR_PORT_C_DATA) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.pc_dat, 7'h00};
      end else if (paddr == pcm_pkg::ADDR_PORT_C_DIR) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.pc_dir, 7'h00};
      end else if (paddr == pcm_pkg::ADDR_PORT_D_DATA) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.pd_dat};
      end else if (paddr == pcm_pkg::ADDR_PORT_D_DIR) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.pd_dir};
      end else if (paddr == pcm_pkg::ADDR_PORT_E_DATA) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.pe_dat};
      end else if (paddr == pcm_pkg::ADDR_PORT_E_DIR) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.pe_dir};
      end else if (paddr == pcm_pkg::ADDR_PIN_STATUS) begin
        nxt_st.rdata = {15'h0000, pc7_in, pe_in, pd_in};
      end else if (paddr == pcm_pkg::ADDR_TIMER2_CONTROL) begin
        nxt_st.rdata = {24'h00_0000, st_ff.cfg.timer2_control};
      end else begin
        nxt_st.rdata = pcm_pkg::RST_WORD;
      end
    end

    // timer outputs: split mode watches the low-byte counter
    t0_ev = timer_ev.t0_split ? timer_ev.t0_low : timer_ev.t0_full;
    t1_ev = timer_ev.t1_split ? timer_ev.t1_low : timer_ev.t1_full;
    nxt_st.t0_cnt  = pcm_stretch(t0_ev, st_ff.t0_cnt);
    nxt_st.t1_cnt  = pcm_stretch(t1_ev, st_ff.t1_cnt);
    nxt_st.t2_out  = timer_ev.t2_ovf;

    // echo outputs idle high outside synchronous mode 0
    nxt_st.rx0_out = (serial_port0.mode == pcm_pkg::SERIAL_MODE_0) ?
                     serial_port0.data : 1'b1;
    nxt_st.rx1_out = (serial_port1.mode == pcm_pkg::SERIAL_MODE_0) ?
                     serial_port1.data : 1'b1;

    // port c pin 7
    pin_bits = pcm_pin_sel(st_ff.cfg.pc_cfg[pcm_pkg::PC_ALT_BIT], wave_addr_bit7, 1'b1,
                           st_ff.cfg.pc_dat, st_ff.cfg.pc_dir);
    nxt_st.pc7_out  = pin_bits[1];
    nxt_st.pc7_oe_n = pin_bits[0];

    // port d: upper bus byte needs both bus mode and word-wide
    bus_hi_sel = (st_ff.cfg.if_mode != pcm_pkg::IF_MODE_PORTS) && st_ff.cfg.ep_wide;
    for (int i = 0; i < 8; i++) begin
      pin_bits = pcm_pin_sel(bus_hi_sel, bus_data_hi_out[i], bus_data_hi_oe,
                             st_ff.cfg.pd_dat[i], st_ff.cfg.pd_dir[i]);
      nxt_st.pd.out[i]  = pin_bits[1];
      nxt_st.pd.oe_n[i] = pin_bits[0];
    end

    // port e: irq6 and reload are inputs, so their pins are released
    alt_val   = {wave_addr_bit8, 2'h0, nxt_st.rx1_out, nxt_st.rx0_out, nxt_st.t2_out,
                 (nxt_st.t1_cnt != 8'h00), (nxt_st.t0_cnt != 8'h00)};
    alt_drive = 8'h9f;
    for (int i = 0; i < 8; i++) begin
      pin_bits = pcm_pin_sel(st_ff.cfg.pe_cfg[i], alt_val[i], alt_drive[i],
                             st_ff.cfg.pe_dat[i], st_ff.cfg.pe_dir[i]);
      nxt_st.pe.out[i]  = pin_bits[1];
      nxt_st.pe.oe_n[i] = pin_bits[0];
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // all pins come up as port inputs, alternates deselected
      st_ff.cfg      <= '0;
      st_ff.pc7_out  <= 1'b0;
      st_ff.pc7_oe_n <= 1'b1;
      st_ff.pd.out   <= pcm_pkg::RST_BYTE;
      st_ff.pd.oe_n  <= ~pcm_pkg::RST_BYTE;
      st_ff.pe.out   <= pcm_pkg::RST_BYTE;
      st_ff.pe.oe_n  <= ~pcm_pkg::RST_BYTE;
      st_ff.t0_cnt   <= pcm_pkg::RST_BYTE;
      st_ff.t1_cnt   <= pcm_pkg::RST_BYTE;
      st_ff.t2_out   <= 1'b0;
      st_ff.rx0_out  <= 1'b1;
      st_ff.rx1_out  <= 1'b1;
      st_ff.rdata    <= pcm_pkg::RST_WORD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // edge inputs
  // ****************************************
  pcm_edge_det #(.RISE(1'b1)) u_irq6 (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (pe_in[pcm_pkg::PE_IRQ6_BIT]),
    .enable  (st_ff.cfg.pe_cfg[pcm_pkg::PE_IRQ6_BIT]),
    .pulse   (ext_irq6_pulse)
  );

  pcm_edge_det #(.RISE(1'b0)) u_timer2_reload_in (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (pe_in[pcm_pkg::PE_TIMER2_RELOAD_IN_BIT]),
    .enable  (st_ff.cfg.pe_cfg[pcm_pkg::PE_TIMER2_RELOAD_IN_BIT] &&
              st_ff.cfg.timer2_control[pcm_pkg::T2_EXT_EN_BIT]),
    .pulse   (timer2_reload_pulse)
  );

  assign pready         = 1'b1;
  assign pslverr        = psel && penable && !mapped;
  assign prdata         = st_ff.rdata;
  assign bus_data_hi_in = pd_in;
  assign pc7_out        = st_ff.pc7_out;
  assign pc7_oe_n       = st_ff.pc7_oe_n;
  assign pd_out         = st_ff.pd.out;
  assign pd_oe_n        = st_ff.pd.oe_n;
  assign pe_out         = st_ff.pe.out;
  assign pe_oe_n        = st_ff.pe.oe_n;

  // ****************************************
  // assertions
  // ****************************************
  property p_pc7_alt;
    @(posedge pclk) disable iff (!presetn)
      st_ff.cfg.pc_cfg[pcm_pkg::PC_ALT_BIT] |=> (pc7_out == $past(wave_addr_bit7)) && !pc7_oe_n;
  endproperty
  a_pc7_alt: assert property (p_pc7_alt) else $error("pc7 not address bit");

  property p_pd_bus;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.cfg.if_mode != pcm_pkg::IF_MODE_PORTS && st_ff.cfg.ep_wide && bus_data_hi_oe)
      |=> (pd_out == $past(bus_data_hi_out)) && (pd_oe_n == 8'h00);
  endproperty
  a_pd_bus: assert property (p_pd_bus) else $error("port d not bus");

  property p_pd_port;
    @(posedge pclk) disable iff (!presetn)
      !st_ff.cfg.ep_wide |=> (pd_out == $past(st_ff.cfg.pd_dat)) &&
                             (pd_oe_n == ~$past(st_ff.cfg.pd_dir));
  endproperty
  a_pd_port: assert property (p_pd_port) else $error("port d not port");

  property p_pe7_alt;
    @(posedge pclk) disable iff (!presetn)
      st_ff.cfg.pe_cfg[pcm_pkg::PE_ADR8_BIT]
      |=> (pe_out[7] == $past(wave_addr_bit8)) && !pe_oe_n[7];
  endproperty
  a_pe7_alt: assert property (p_pe7_alt) else $error("pe7 not address bit 8");

  property p_t0_split;
    @(posedge pclk) disable iff (!presetn)
      (timer_ev.t0_split && timer_ev.t0_low) |=> (st_ff.t0_cnt == CORE_CLOCK_OUTPUT_CYCLES);
  endproperty
  a_t0_split: assert property (p_t0_split) else $error("split overflow lost");

  property p_t0_pulse;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.cfg.pe_cfg[0] && $past(st_ff.cfg.pe_cfg[0]) && st_ff.t0_cnt == 8'h00 && !t0_ev)
      |=> !pe_out[0];
  endproperty
  a_t0_pulse: assert property (p_t0_pulse) else $error("timer0 out stuck high");

  property p_t2_out;
    @(posedge pclk) disable iff (!presetn)
      st_ff.cfg.pe_cfg[pcm_pkg::PE_T2_BIT] |=> (pe_out[2] == $past(timer_ev.t2_ovf));
  endproperty
  a_t2_out: assert property (p_t2_out) else $error("timer2 out wrong");

  property p_rx_idle;
    @(posedge pclk) disable iff (!presetn)
      (serial_port0.mode != pcm_pkg::SERIAL_MODE_0 && serial_port1.mode != pcm_pkg::SERIAL_MODE_0)
      |=> st_ff.rx0_out && st_ff.rx1_out;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("echo not high");

  property p_pe_input;
    @(posedge pclk) disable iff (!presetn)
      st_ff.cfg.pe_cfg[pcm_pkg::PE_IRQ6_BIT] |=> pe_oe_n[pcm_pkg::PE_IRQ6_BIT];
  endproperty
  a_pe_input: assert property (p_pe_input) else $error("irq6 pin driven");

endmodule : pcm_port_mux

/* include/pcm_pkg.sv */
// package: register map, field positions, reset values and carriers of the port c/d/e mux
package pcm_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_PORT_C_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_PORT_E_CONFIG   = 8'h04;
  localparam logic [7:0] ADDR_INTERFACE_CFG   = 8'h08;
  localparam logic [7:0] ADDR_ENDPOINT_FIFO   = 8'h0c;
  localparam logic [7:0] ADDR_PORT_C_DATA     = 8'h10;
  localparam logic [7:0] ADDR_PORT_C_DIR      = 8'h14;
  localparam logic [7:0] ADDR_PORT_D_DATA     = 8'h18;
  localparam logic [7:0] ADDR_PORT_D_DIR      = 8'h1c;
  localparam logic [7:0] ADDR_PORT_E_DATA     = 8'h20;
  localparam logic [7:0] ADDR_PORT_E_DIR      = 8'h24;
  localparam logic [7:0] ADDR_PIN_STATUS      = 8'h28;
  localparam logic [7:0] ADDR_TIMER2_CONTROL  = 8'h2c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PC_ALT_BIT       = 7;
  localparam int WORDWIDE_BIT     = 0;
  localparam int T2_EXT_EN_BIT    = 3;
  localparam int PE_T0_BIT        = 0;
  localparam int PE_T1_BIT        = 1;
  localparam int PE_T2_BIT        = 2;
  localparam int PE_RX0_BIT       = 3;
  localparam int PE_RX1_BIT       = 4;
  localparam int PE_IRQ6_BIT      = 5;
  localparam int PE_TIMER2_RELOAD_IN_BIT      = 6;
  localparam int PE_ADR8_BIT      = 7;

  // ****************************************
  // encodings and reset values
  // ****************************************
  localparam logic [1:0] IF_MODE_PORTS   = 2'h0;
  localparam logic [1:0] SERIAL_MODE_0   = 2'h0;
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [7:0] CORE_CLOCK_OUTPUT_CYCLES_DEF = 8'h01;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] pc_cfg;
    logic [7:0] pe_cfg;
    logic [1:0] if_mode;
    logic       ep_wide;
    logic [7:0] timer2_control;
    logic       pc_dat;
    logic       pc_dir;
    logic [7:0] pd_dat;
    logic [7:0] pd_dir;
    logic [7:0] pe_dat;
    logic [7:0] pe_dir;
  } pcm_cfg_t;

  typedef struct packed {
    logic t0_full;
    logic t0_low;
    logic t0_split;
    logic t1_full;
    logic t1_low;
    logic t1_split;
    logic t2_ovf;
  } pcm_timer_ev_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       data;
  } pcm_serial_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pcm_pin8_t;

  typedef struct packed {
    logic prev;
    logic pulse;
  } pcm_edge_t;

endpackage : pcm_pkg

/* design/pcm_edge_det.sv */
// edge detector: one-cycle registered pulse on a chosen edge of a synchronous input
`timescale 1ns/1ps
module pcm_edge_det #(
  parameter bit RISE = 1'b1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sig_in,
  input  wire logic enable,
  output logic      pulse
);

  pcm_pkg::pcm_edge_t st_ff;
  pcm_pkg::pcm_edge_t nxt_st;

  always_comb begin
    nxt_st.prev  = sig_in;
    // level alone never fires, only a change while enabled
    nxt_st.pulse = enable && (RISE ? (sig_in && !st_ff.prev) : (!sig_in && st_ff.prev));
  end

  // prev resets to the level that cannot start an edge, so reset release never fires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.prev  <= RISE ? 1'b1 : 1'b0;
      st_ff.pulse <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse = st_ff.pulse;

  // ****************************************
  // assertions
  // ****************************************
  property p_edge_fires;
    @(posedge pclk) disable iff (!presetn)
      (enable && (RISE ? (sig_in && !st_ff.prev) : (!sig_in && st_ff.prev))) |=> pulse;
  endproperty
  a_edge_fires: assert property (p_edge_fires) else $error("edge missed");

  property p_edge_gated;
    @(posedge pclk) disable iff (!presetn)
      !enable |=> !pulse;
  endproperty
  a_edge_gated: assert property (p_edge_gated) else $error("pulse while disabled");

  property p_edge_level;
    @(posedge pclk) disable iff (!presetn)
      ($stable(sig_in) && $past(presetn)) |=> !pulse;
  endproperty
  a_edge_level: assert property (p_edge_level) else $error("pulse without edge");

endmodule : pcm_edge_det

/* sim/pcm_board_model.sv */
// board-side model: pull-ups and optional board drivers on pin c7, port d and port e
`timescale 1ns/1ps
module pcm_board_model (
  input  wire logic [16:0] dut_out,
  input  wire logic [16:0] dut_oe_n,
  input  wire logic [16:0] brd_val,
  input  wire logic [16:0] brd_en,
  output logic      [16:0] pin_lvl
);
  // released, undriven pins sit at the pull-up, never at a stale value
  assign pin_lvl = (~dut_oe_n & dut_out) | (dut_oe_n & brd_en & brd_val)
                 | (dut_oe_n & ~brd_en);
endmodule : pcm_board_model

/* sim/tb_port_cde_alt_function_mux.sv */
// self-checking bench for the port c/d/e alternate-function mux
`timescale 1ns/1ps
module tb_port_cde_alt_function_mux;
  localparam logic [7:0]  CK = 8'h02;
  localparam int          SEL [6] = '{2, 3, 1, 0, 0, 1};
  logic                   pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                   pwrite = 1'b0, wa7 = 1'b0, wa8 = 1'b0, bdoe = 1'b0;
  logic                   pready, pslverr, er, irq6, t2rl;
  logic [7:0]             paddr = 8'h00, bdo = 8'h00, bdi;
  logic [31:0]            pwdata = 32'h0000_0000, prdata, rd, v;
  pcm_pkg::pcm_timer_ev_t timer_ev = 7'h00;
  pcm_pkg::pcm_serial_t   sp0 = 3'h0, sp1 = 3'h0;
  wire  [16:0]            d_out, d_oe_n;
  logic [16:0]            pins, brd_val = 17'h0_0000, brd_en = 17'h0_0000;
  int                     fail_count = 0, tests_run = 0, seed = 47834, na, nb;

  always #12.5 pclk = ~pclk;
  pcm_port_mux #(.CORE_CLOCK_OUTPUT_CYCLES(CK)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_ev(timer_ev), .serial_port0(sp0), .serial_port1(sp1), .wave_addr_bit7(wa7),
    .wave_addr_bit8(wa8), .bus_data_hi_out(bdo), .bus_data_hi_oe(bdoe), .bus_data_hi_in(bdi),
    .ext_irq6_pulse(irq6), .timer2_reload_pulse(t2rl), .pc7_in(pins[16]), .pc7_out(d_out[16]),
    .pc7_oe_n(d_oe_n[16]), .pd_in(pins[15:8]), .pd_out(d_out[15:8]), .pd_oe_n(d_oe_n[15:8]),
    .pe_in(pins[7:0]), .pe_out(d_out[7:0]), .pe_oe_n(d_oe_n[7:0]));
  pcm_board_model board (.dut_out(d_out), .dut_oe_n(d_oe_n), .brd_val(brd_val),
    .brd_en(brd_en), .pin_lvl(pins));

  // ****************************************
  // bench tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  function automatic logic echo(pcm_pkg::pcm_serial_t s);
    return (s.mode === pcm_pkg::SERIAL_MODE_0) ? s.data : 1'b1;
  endfunction : echo
  // outputs are registered: sample half a cycle after the edge that loads them
  task automatic settle;
    @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic ev_pulse(input logic [6:0] ev, input int pin, input int len);
    @(posedge pclk);
    timer_ev <= ev;
    @(posedge pclk);
    timer_ev <= 7'h00;
    for (int k = 0; k <= len; k++) begin
      @(negedge pclk);
      check(32'(d_out[pin]), 32'(k < len));
    end
  endtask : ev_pulse
  task automatic count_edges;
    na = 0;
    nb = 0;
    repeat (6) begin
      @(negedge pclk);
      na += int'(irq6 === 1'b1);
      nb += int'(t2rl === 1'b1);
    end
  endtask : count_edges

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(32'(d_oe_n), 32'h0001_ffff);
    @(posedge pclk);
    brd_en <= 17'h1_ffff;
    brd_val <= 17'($random(seed));
    apb(1'b0, pcm_pkg::ADDR_PIN_STATUS, 32'h0000_0000);
    check(rd, {15'h0000, brd_val[16], brd_val[7:0], brd_val[15:8]});
    check(32'(bdi), 32'(brd_val[15:8]));
    apb(1'b0, 8'h30, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(er), 32'h0000_0001);
    // alternates toggle underneath the port settings and must not leak out
    repeat (4) begin
      v = $random(seed);
      @(posedge pclk);
      brd_en <= 17'h0_0000;
      wa7 <= ~v[23];
      wa8 <= ~v[7];
      for (int j = 0; j < 6; j++) begin
        wr(pcm_pkg::ADDR_PORT_C_DATA + 8'(4 * j), {24'h00_0000, v[8 * SEL[j] +: 8]});
      end
      settle;
      check(32'(d_oe_n), {15'h0000, ~{v[31], v[7:0], v[15:8]}});
      check(32'(d_out & ~d_oe_n), {15'h0000, v[23] & v[31], {2{v[7:0] & v[15:8]}}});
    end
    wr(pcm_pkg::ADDR_PORT_E_CONFIG, 32'h0000_00ff);
    wr(pcm_pkg::ADDR_PORT_C_CONFIG, 32'h0000_0080);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      wa7 <= i[0];
      wa8 <= i[1];
      sp0 <= i[2:0];
      sp1 <= ~i[2:0];
      settle;
      check(32'({d_oe_n[16], d_oe_n[7:0]}), 32'h0000_0060);
      check(32'({d_out[16], d_out[7], d_out[4:0]}),
            {25'h000_0000, wa7, wa8, echo(sp1), echo(sp0), 3'h0});
    end
    ev_pulse(7'h40, 0, int'(CK));
    ev_pulse(7'h30, 0, int'(CK));
    ev_pulse(7'h50, 0, 0);
    ev_pulse(7'h0a, 1, 0);
    ev_pulse(7'h08, 1, int'(CK));
    ev_pulse(7'h06, 1, int'(CK));
    ev_pulse(7'h01, 2, 1);
    @(posedge pclk);
    brd_en <= 17'h0_0060;
    brd_val <= 17'h0_0040;
    repeat (3) @(posedge pclk);
    brd_val <= 17'h0_0020;
    count_edges;
    check(32'(na), 32'h0000_0001);
    check(32'(nb), 32'h0000_0000);
    wr(pcm_pkg::ADDR_TIMER2_CONTROL, 32'h0000_0008);
    @(posedge pclk);
    brd_val <= 17'h0_0040;
    repeat (3) @(posedge pclk);
    brd_val <= 17'h0_0000;
    count_edges;
    check(32'(na), 32'h0000_0000);
    check(32'(nb), 32'h0000_0001);
    wr(pcm_pkg::ADDR_PORT_D_DIR, 32'h0000_0000);
    // bus byte only when both bus mode and word-wide are set
    for (int w = 0; w < 4; w++) begin
      wr(pcm_pkg::ADDR_INTERFACE_CFG, 32'(w[1]));
      wr(pcm_pkg::ADDR_ENDPOINT_FIFO, 32'(w[0]));
      @(posedge pclk);
      bdo <= 8'($random(seed));
      bdoe <= 1'b1;
      settle;
      check(32'(d_oe_n[15:8]), (w == 3) ? 32'h0000_0000 : 32'h0000_00ff);
      check(32'(d_out[15:8] & ~d_oe_n[15:8]), (w == 3) ? 32'(bdo) : 32'h0000_0000);
    end
    // bus selected but not driving: the pins are released
    @(posedge pclk);
    bdoe <= 1'b0;
    settle;
    check(32'(d_oe_n[15:8]), 32'h0000_00ff);
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    print_verdict;
  end
endmodule : tb_port_cde_alt_function_mux
